// ---- common/smec_pkg.sv ----
// Package with constants and carrier types for the standby mode entry control block
package smec_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IRQEN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int BIT_STANDBY_SELECT_BIT = 0;
  localparam int BIT_CCR_I = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [2:0] IRQEN_RESET = 3'h0;
  localparam int INHIBIT_CYCLES = 1;
  localparam int SYNC_DEPTH = 3;
  typedef enum {SMEC_ACTIVE, SMEC_SLEEP, SMEC_SW_HW_STANDBY_PIN, SMEC_HW_HW_STANDBY_PIN, SMEC_RESET} smec_mode_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } smec_bus_req_t;
  typedef struct packed {
    logic [2:0] resetPinSync;
    logic [2:0] standbyPinSync;
    logic [2:0] nmiSync;
    logic [2:0] irqZeroSync;
    logic [2:0] irqOneSync;
    logic [2:0] irqTwoSync;
    logic standbySelectBit;
    logic ccrMask;
    logic [2:0] irqEnable;
    logic nmiPending;
    logic nmiArmed;
    logic [1:0] inhibitCnt;
    logic [2:0] mode;
    logic [31:0] readdata;
    logic readValid;
    logic irqAccept;
    logic nmiAccept;
    logic abortInstr;
  } smec_state_t;
endpackage : smec_pkg

// ---- hw/smec_top.sv ----
// Standby mode entry control: power-down sequencing with an Avalon-MM register slave
module smec_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin_n,
  input wire logic nmi_n,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic ext_irq_two_n,
  input wire logic sleepExec,
  input wire logic instrDone,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic swStandby,
  output logic hwStandby,
  output logic inReset,
  output logic abortInstr,
  output logic irqAccept,
  output logic nmiAccept
);
  smec_pkg::smec_state_t st_r;
  smec_pkg::smec_state_t st_nxt;
  smec_pkg::smec_mode_t modeCur;
  logic resetLow;
  logic standbyLow;
  logic nmiLow;
  logic irqZeroLow;
  logic irqOneLow;
  logic irqTwoLow;
  logic irqsQuiet;
  logic sleepOk;

  // Stable level once the second and third stages agree; otherwise keep last view
  function automatic logic syncLow(input logic [2:0] s, input logic prev);
    if (s[1] == s[2]) begin
      syncLow = ~s[2];
    end else begin
      syncLow = prev;
    end
  endfunction : syncLow

  logic resetLow_r;
  logic standbyLow_r;
  logic nmiLow_r;
  logic [2:0] irqLow_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resetLow_r <= 1'b1;
      standbyLow_r <= 1'b0;
      nmiLow_r <= 1'b0;
      irqLow_r <= 3'h0;
    end else begin
      resetLow_r <= resetLow;
      standbyLow_r <= standbyLow;
      nmiLow_r <= nmiLow;
      irqLow_r <= {irqTwoLow, irqOneLow, irqZeroLow};
    end
  end

  always_comb begin
    resetLow = syncLow(st_r.resetPinSync, resetLow_r);
    standbyLow = syncLow(st_r.standbyPinSync, standbyLow_r);
    nmiLow = syncLow(st_r.nmiSync, nmiLow_r);
    irqZeroLow = syncLow(st_r.irqZeroSync, irqLow_r[0]);
    irqOneLow = syncLow(st_r.irqOneSync, irqLow_r[1]);
    irqTwoLow = syncLow(st_r.irqTwoSync, irqLow_r[2]);
    modeCur = smec_pkg::smec_mode_t'(st_r.mode);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.resetPinSync = {st_r.resetPinSync[1:0], reset_pin_n};
    st_nxt.standbyPinSync = {st_r.standbyPinSync[1:0], hw_standby_pin_n};
    st_nxt.nmiSync = {st_r.nmiSync[1:0], nmi_n};
    st_nxt.irqZeroSync = {st_r.irqZeroSync[1:0], ext_irq_zero_n};
    st_nxt.irqOneSync = {st_r.irqOneSync[1:0], ext_irq_one_n};
    st_nxt.irqTwoSync = {st_r.irqTwoSync[1:0], ext_irq_two_n};
    st_nxt.readValid = 1'b0;
    st_nxt.irqAccept = 1'b0;
    st_nxt.nmiAccept = 1'b0;
    st_nxt.abortInstr = 1'b0;
    // Interrupts with enable off are ignored, not latched for later
    irqsQuiet = ~((st_r.irqEnable[0] & irqZeroLow) | (st_r.irqEnable[2] & irqTwoLow));
    sleepOk = ~resetLow & ~standbyLow & ~st_r.nmiPending;
    // Register access, one wait state for reads
    if (avs_write & ~resetLow & ~standbyLow) begin
      case (avs_address)
        smec_pkg::ADDR_CTRL: begin
          st_nxt.standbySelectBit = avs_writedata[smec_pkg::BIT_STANDBY_SELECT_BIT];
          st_nxt.ccrMask = avs_writedata[smec_pkg::BIT_CCR_I];
        end
        smec_pkg::ADDR_IRQEN: st_nxt.irqEnable = avs_writedata[2:0];
        default: ;
      endcase
    end
    if (avs_read & ~st_r.readValid) begin
      st_nxt.readValid = 1'b1;
      case (avs_address)
        smec_pkg::ADDR_CTRL: st_nxt.readdata = {30'h0, st_r.ccrMask, st_r.standbySelectBit};
        smec_pkg::ADDR_IRQEN: st_nxt.readdata = {29'h0, st_r.irqEnable};
        smec_pkg::ADDR_STATUS: st_nxt.readdata = {25'h0, st_r.nmiArmed, st_r.nmiPending,
                                                   st_r.inhibitCnt, st_r.mode};
        default: st_nxt.readdata = 32'h00000000;
      endcase
    end
    // NMI is only sampled outside reset
    if (~resetLow & nmiLow & ~nmiLow_r) begin
      st_nxt.nmiPending = 1'b1;
    end
    if (instrDone & ~resetLow) begin
      st_nxt.nmiArmed = 1'b1;
    end
    if (st_r.inhibitCnt != 2'h0) begin
      st_nxt.inhibitCnt = st_r.inhibitCnt - 2'h1;
    end
    case (modeCur)
      smec_pkg::SMEC_ACTIVE: begin
        if (st_r.inhibitCnt == 2'h0) begin
          if (st_r.nmiPending & st_r.nmiArmed) begin
            st_nxt.nmiAccept = 1'b1;
            // A fresh edge in the accept cycle wins, so a second NMI is not lost
            st_nxt.nmiPending = ~resetLow & nmiLow & ~nmiLow_r;
          end else if (~st_r.ccrMask & st_r.irqEnable[1] & irqOneLow) begin
            st_nxt.irqAccept = 1'b1;
          end
        end
        if (sleepExec & st_r.standbySelectBit & sleepOk) begin
          if (irqsQuiet | st_r.ccrMask) begin
            st_nxt.mode = 3'(smec_pkg::SMEC_SW_HW_STANDBY_PIN);
          end else begin
            st_nxt.mode = 3'(smec_pkg::SMEC_SLEEP);
          end
        end else if (sleepExec) begin
          st_nxt.mode = 3'(smec_pkg::SMEC_SLEEP);
        end
      end
      smec_pkg::SMEC_SLEEP, smec_pkg::SMEC_SW_HW_STANDBY_PIN: begin
        // Wake on NMI or an enabled, unmasked external interrupt
        if (st_r.nmiPending | (~st_r.ccrMask & |(st_r.irqEnable & irqLow_r))) begin
          st_nxt.mode = 3'(smec_pkg::SMEC_ACTIVE);
        end
      end
      smec_pkg::SMEC_HW_HW_STANDBY_PIN: begin
        if (~standbyLow) begin
          st_nxt.mode = 3'(smec_pkg::SMEC_RESET);
        end
      end
      smec_pkg::SMEC_RESET: begin
        if (~resetLow) begin
          st_nxt.mode = 3'(smec_pkg::SMEC_ACTIVE);
          st_nxt.inhibitCnt = 2'(smec_pkg::INHIBIT_CYCLES);
        end
      end
      default: st_nxt.mode = 3'(smec_pkg::SMEC_RESET);
    endcase
    // Reset pin low or hardware standby clears enables and NMI history so a held line is not taken at once
    if (resetLow | (modeCur == smec_pkg::SMEC_HW_HW_STANDBY_PIN)) begin
      st_nxt.irqEnable = smec_pkg::IRQEN_RESET;
      st_nxt.standbySelectBit = 1'b0;
      st_nxt.ccrMask = 1'b1;
      st_nxt.nmiPending = 1'b0;
      st_nxt.nmiArmed = 1'b0;
      if (modeCur != smec_pkg::SMEC_HW_HW_STANDBY_PIN) begin
        st_nxt.mode = 3'(smec_pkg::SMEC_RESET);
      end
    end
    // Standby pin wins over everything; no wait for the instruction in flight
    if (standbyLow) begin
      st_nxt.mode = 3'(smec_pkg::SMEC_HW_HW_STANDBY_PIN);
      st_nxt.abortInstr = (modeCur != smec_pkg::SMEC_HW_HW_STANDBY_PIN);
      st_nxt.irqAccept = 1'b0;
      st_nxt.nmiAccept = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.resetPinSync <= 3'h0;
      st_r.standbyPinSync <= 3'h7;
      st_r.nmiSync <= 3'h7;
      st_r.irqZeroSync <= 3'h7;
      st_r.irqOneSync <= 3'h7;
      st_r.irqTwoSync <= 3'h7;
      st_r.ccrMask <= 1'b1;
      st_r.irqEnable <= smec_pkg::IRQEN_RESET;
      st_r.mode <= 3'(smec_pkg::SMEC_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    avs_readdata = st_r.readdata;
    avs_waitrequest = avs_read & ~st_r.readValid;
    swStandby = (modeCur == smec_pkg::SMEC_SW_HW_STANDBY_PIN);
    hwStandby = (modeCur == smec_pkg::SMEC_HW_HW_STANDBY_PIN);
    inReset = (modeCur == smec_pkg::SMEC_RESET);
    abortInstr = st_r.abortInstr;
    irqAccept = st_r.irqAccept;
    nmiAccept = st_r.nmiAccept;
  end
endmodule : smec_top

// ---- test/smec_partner.sv ----
// Model of the external system that drives the pins
module smec_partner (
  input wire logic clk_sys,
  output logic reset_pin_n,
  output logic hw_standby_pin_n,
  output logic nmi_n,
  output logic [2:0] irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reset_pin_n, hw_standby_pin_n, nmi_n, irq_n} = 6'h1f;
  // Drives all six pin bits together, updated at the next rising clock edge
  task automatic drive(input logic [5:0] v);
    @(posedge clk_sys);
    {reset_pin_n, hw_standby_pin_n, nmi_n, irq_n} <= v;
  endtask : drive
endmodule : smec_partner

// ---- test/smec_assertions.sv ----
// Checker for the standby entry control ports
module smec_assertions (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin_n,
  input wire logic sleepExec,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic swStandby,
  input wire logic hwStandby,
  input wire logic inReset,
  input wire logic abortInstr,
  input wire logic irqAccept,
  input wire logic nmiAccept
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Six cycles covers the pin synchroniser plus the mode register
  AST_HW: assert property (!hw_standby_pin_n [*6] |-> hwStandby)
    else $error("no hw standby");
  AST_ABORT: assert property ($rose(hwStandby) |-> ##[0:1] abortInstr)
    else $error("no abort pulse");
  AST_EXIT: assert property ($fell(hwStandby) |-> inReset)
    else $error("hw exit skips reset");
  AST_INH: assert property ($fell(inReset) |-> (!irqAccept && !nmiAccept) ##1 (!irqAccept && !nmiAccept))
    else $error("accept after reset");
  AST_RPIN: assert property ($fell(inReset) && !hwStandby |-> $past(reset_pin_n))
    else $error("reset left with pin low");
  AST_NMI: assert property (inReset && $past(inReset) |-> !nmiAccept)
    else $error("nmi in reset");
  AST_WR: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  AST_SW: assert property ($rose(swStandby) |-> $past(sleepExec) && $past(hw_standby_pin_n))
    else $error("sw standby uncaused");
  cover property ($rose(swStandby));
  cover property ($rose(hwStandby));
  cover property (irqAccept);
  cover property (nmiAccept);
endmodule : smec_assertions
bind smec_top smec_assertions u_chk (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the standby entry control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, sleepExec = 0, instrDone = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, swStandby, hwStandby, inReset, abortInstr, irqAccept, nmiAccept;
  logic reset_pin_n, hw_standby_pin_n, nmi_n;
  logic [2:0] irq_n, ln;
  logic [31:0] expQ[$];
  int num_errors = 0, checks_done = 0, cyc = 0, seen;
  // Fields: mask, select, enables, lines, expected standby
  logic [8:0] cases [5] = '{9'b01_000_000_1, 9'b01_101_111_1, 9'b01_001_110_0,
    9'b11_101_000_1, 9'b00_000_111_0};
  always #5 clk_sys = ~clk_sys;
  smec_partner u_part (.clk_sys(clk_sys), .reset_pin_n(reset_pin_n),
    .hw_standby_pin_n(hw_standby_pin_n), .nmi_n(nmi_n), .irq_n(irq_n));
  smec_top dut (.*, .ext_irq_zero_n(irq_n[0]), .ext_irq_one_n(irq_n[1]),
    .ext_irq_two_n(irq_n[2]));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= r;
    avs_write <= !r;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1, a, 32'h0);
  endtask : rd
  // Standby pin low, then back up; recovery must go through reset
  task automatic recover(input logic [2:0] irq);
    u_part.drive({3'b101, irq});
    repeat (40) if (hwStandby !== 1'b1) @(negedge clk_sys);
    chk("hwStandby", hwStandby, 1);
    u_part.drive({3'b111, irq});
    repeat (40) if (inReset !== 1'b0 || hwStandby !== 1'b0) @(negedge clk_sys);
    rd(smec_pkg::ADDR_IRQEN, 32'h0);
  endtask : recover
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("readdata", avs_readdata, expQ.pop_front());
  end
  initial begin
    void'($urandom(9087));
    repeat (6) @(posedge clk_sys);
    srst <= 0;
    foreach (cases[i]) begin
      ln = cases[i][3:1];
      ln[1] = 1'($urandom_range(1));
      recover(ln);
      bus(0, smec_pkg::ADDR_IRQEN, 32'(cases[i][6:4]));
      bus(0, smec_pkg::ADDR_CTRL, 32'(cases[i][8:7]));
      @(posedge clk_sys);
      sleepExec <= 1;
      @(posedge clk_sys);
      sleepExec <= 0;
      repeat (2) @(negedge clk_sys);
      chk("swStandby", swStandby, 32'(cases[i][0]));
      $display("sleep case %0d done", i);
    end
    // Irq-one line held low across recovery, mask cleared, enable still off
    recover(3'b101);
    bus(0, smec_pkg::ADDR_CTRL, 32'h0);
    seen = 0;
    repeat (8) @(negedge clk_sys) if (irqAccept === 1'b1) seen++;
    chk("irqAccept early", seen, 0);
    bus(0, smec_pkg::ADDR_IRQEN, 32'h2);
    repeat (8) @(negedge clk_sys) if (irqAccept === 1'b1) seen++;
    chk("irqAccept", 32'(seen != 0), 1);
    rd(4'hc, 32'h0);
    repeat (3) @(posedge clk_sys);
    $display("irq and bus test done");
    // NMI edge after recovery waits until the first instruction completes
    u_part.drive({3'b110, 3'b101});
    seen = 0;
    repeat (8) @(negedge clk_sys) if (nmiAccept !== 1'b0) seen++;
    chk("nmiAccept early", seen, 0);
    rd(smec_pkg::ADDR_STATUS, 32'h20);
    @(posedge clk_sys);
    instrDone <= 1;
    @(posedge clk_sys);
    instrDone <= 0;
    repeat (8) @(negedge clk_sys) if (nmiAccept !== 1'b0) seen++;
    chk("nmiAccept", seen, 1);
    rd(smec_pkg::ADDR_STATUS, 32'h40);
    repeat (3) @(posedge clk_sys);
    $display("nmi test done");
    wrap_up();
  end
endmodule : tb_top
